// ===== shared/query_consts.svh
// Purpose: Offsets, table values and reset values of the query table.
// Assumes: Included by bare name after the package.
// Notes: Offsets are word addresses; values are the low data byte.
`ifndef QUERY_CONSTS_SVH
`define QUERY_CONSTS_SVH
// ============================================================
// Table offsets
`define QO_RSV_LAST 8'h0F
`define QO_SIG_Q 8'h10
`define QO_SIG_R 8'h11
`define QO_SIG_Y 8'h12
`define QO_CMD_LO 8'h13
`define QO_CMD_HI 8'h14
`define QO_EXT_LO 8'h15
`define QO_EXT_HI 8'h16
`define QO_ALT_LO 8'h17
`define QO_ALT_HI 8'h18
`define QO_SEC_LO 8'h19
`define QO_SEC_HI 8'h1A
`define QO_VCC_MIN 8'h1B
`define QO_VCC_MAX 8'h1C
`define QO_VPP_MIN 8'h1D
`define QO_VPP_MAX 8'h1E
`define QO_WORD_TYP 8'h1F
`define QO_BUF_TYP 8'h20
`define QO_ERASE_TYP 8'h21
`define QO_CHIP_TYP 8'h22
`define QO_WORD_MAX 8'h23
`define QO_BUF_MAX 8'h24
`define QO_ERASE_MAX 8'h25
`define QO_CHIP_MAX 8'h26
// ============================================================
// Table values
`define QV_SIG_Q 8'h51
`define QV_SIG_R 8'h52
`define QV_SIG_Y 8'h59
`define QV_EXT_LO 8'h0A
`define QV_EXT_HI 8'h01
`define QV_NONE 8'h00
`define QV_VCC_MIN 8'h17
`define QV_VCC_MAX 8'h20
`define QV_VPP_MIN 8'h85
`define QV_VPP_MAX 8'h95
`define QV_WORD_TYP 8'h06
`define QV_BUF_TYP_BIG 8'h0B
`define QV_BUF_TYP_SMALL 8'h0A
`define QV_ERASE_TYP 8'h0A
`define QV_WORD_MAX 8'h02
`define QV_BUF_MAX_SMALL 8'h02
`define QV_BUF_MAX_BIG 8'h01
`define QV_ERASE_MAX 8'h02
// ============================================================
// Reset values and upper data byte
`define QS_DQ_RESET 16'h0000
`define QS_UPPER_BYTE 8'h00
`endif

// ===== shared/query_pkg.sv
// Purpose: Types shared by the query table modules.
// Assumes: Nothing beyond the constants header.
// Notes: Enumerations carry no explicit codes.
package query_pkg;
    // ============================================================
    // Types
    typedef enum {MODE_ARRAY, MODE_QUERY} query_mode_type;
    typedef enum {DENS_256, DENS_512, DENS_1024} density_type;
    typedef struct packed
    {
        query_mode_type mode;
        logic rd_pend;
        logic rd_valid;
        logic [15:0] dq;
    } table_state_type;
    typedef struct packed
    {
        logic [15:0] data;
    } rom_state_type;
endpackage

// ===== shared/query_rom_if.sv
// Purpose: Read path between the table control and the table store.
// Assumes: One clock; data appears one edge after rd_en.
// Notes: Data comes from a register in the store.
`timescale 1ns/1ps
`default_nettype none
interface query_rom_if #(parameter int ADDR_W = 26);
    logic rd_en;
    logic [ADDR_W-1:0] addr;
    logic [15:0] data;
    // ============================================================
    // Views
    modport requester (output rd_en, output addr, input data);
    modport table_rom (input rd_en, input addr, output data);
endinterface
`default_nettype wire

// ===== hw/query_rom.sv
// Purpose: Fixed query table store with registered read data.
// Assumes: Address is a word address; upper address bits must be zero.
// Notes: Unlisted and reserved offsets read as zero.
`timescale 1ns/1ps
`default_nettype none
module query_rom
#(
    parameter int ADDR_W = 26,
    parameter query_pkg::density_type DENSITY = query_pkg::DENS_1024,
    parameter logic [15:0] CMD_SET_CODE = 16'h00A5
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Table read port
    query_rom_if.table_rom bus
);
    import query_pkg::*;
`include "query_consts.svh"
    rom_state_type state_reg;
    rom_state_type state_next;
    logic [7:0] byte_sel;
    // ============================================================
    // Lookup of the addressed byte.
    always_comb
    begin
        byte_sel = `QV_NONE;
        if (bus.addr[ADDR_W-1:8] == '0)
        begin
            case (bus.addr[7:0])
                `QO_SIG_Q: byte_sel = `QV_SIG_Q;
                `QO_SIG_R: byte_sel = `QV_SIG_R;
                `QO_SIG_Y: byte_sel = `QV_SIG_Y;
                `QO_CMD_LO: byte_sel = CMD_SET_CODE[7:0];
                `QO_CMD_HI: byte_sel = CMD_SET_CODE[15:8];
                `QO_EXT_LO: byte_sel = `QV_EXT_LO;
                `QO_EXT_HI: byte_sel = `QV_EXT_HI;
                `QO_VCC_MIN: byte_sel = `QV_VCC_MIN;
                `QO_VCC_MAX: byte_sel = `QV_VCC_MAX;
                `QO_VPP_MIN: byte_sel = `QV_VPP_MIN;
                `QO_VPP_MAX: byte_sel = `QV_VPP_MAX;
                `QO_WORD_TYP: byte_sel = `QV_WORD_TYP;
                `QO_BUF_TYP: byte_sel = (DENSITY == DENS_1024) ? `QV_BUF_TYP_BIG : `QV_BUF_TYP_SMALL;
                `QO_ERASE_TYP: byte_sel = `QV_ERASE_TYP;
                `QO_WORD_MAX: byte_sel = `QV_WORD_MAX;
                `QO_BUF_MAX: byte_sel = (DENSITY == DENS_1024) ? `QV_BUF_MAX_BIG : `QV_BUF_MAX_SMALL;
                `QO_ERASE_MAX: byte_sel = `QV_ERASE_MAX;
                // Alternate set, secondary table, chip erase and reserved read zero.
                default: byte_sel = `QV_NONE;
            endcase
        end
    end
    // Next state: capture only on a read, upper byte always zero.
    always_comb
    begin
        state_next = state_reg;
        if (bus.rd_en)
        begin
            state_next.data = {`QS_UPPER_BYTE, byte_sel};
        end
    end
    // State register.
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= '{data: `QS_DQ_RESET};
        end
        else
        begin
            state_reg <= state_next;
        end
    end
    assign bus.data = state_reg.data;
endmodule
`default_nettype wire

// ===== hw/flash_query_info_table.sv
// Purpose: Query information table of a 16-bit flash, read in query mode.
// Assumes: Command decoding elsewhere gives enter and exit pulses.
// Notes: Reads are pipelined, answer two edges after the request.
// Notes on behaviour
// - Table byte appears on the low data byte.
// - Upper data byte always reads zero.
// - Word addressing, standard table starts at 10h.
// - Offsets 10h to 12h read Q, R, Y.
// - Offsets 13h, 14h give command-set code.
// - Extended table pointer reads 0Ah then 01h.
// - Alternate command-set code reads zero.
// - Secondary table pointer reads zero.
// - Core supply bytes read 17h and 20h.
// - Programming supply bytes read 85h and 95h.
// - Typical word program exponent reads 06h.
// - Buffer write exponent depends on density.
// - Typical block erase exponent reads 0Ah.
// - Chip erase entries at 22h, 26h zero.
// - Word program multiplier exponent reads 02h.
// - Buffer write multiplier depends on density.
// - Block erase multiplier exponent reads 02h.
// - Offsets 01h to 0Fh stay reserved.
`timescale 1ns/1ps
`default_nettype none
module flash_query_info_table
#(
    parameter int ADDR_W = 26,
    parameter query_pkg::density_type DENSITY = query_pkg::DENS_1024,
    // Command-set code value is arbitrary.
    parameter logic [15:0] CMD_SET_CODE = 16'h00A5
)
(
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    // Mode commands
    input wire logic I_QUERY_ENTER,
    input wire logic I_QUERY_EXIT,
    // Read request
    input wire logic I_RD_REQ,
    input wire logic [ADDR_W-1:0] I_ADDR,
    // Read answer and mode
    output logic [15:0] O_DQ,
    output logic O_RD_VALID,
    output logic O_QUERY_MODE
);
    import query_pkg::*;
`include "query_consts.svh"
    // ============================================================
    // Storage and control state
    table_state_type state_reg;
    table_state_type state_next;
    logic rd_take;
    query_rom_if #(.ADDR_W(ADDR_W)) rom_bus ();

    // Table store with registered read data.
    query_rom
    #(
        .ADDR_W(ADDR_W),
        .DENSITY(DENSITY),
        .CMD_SET_CODE(CMD_SET_CODE)
    )
    u_rom
    (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RSTN),
        .bus(rom_bus.requester)
    );

    // A read is served only while query mode is active.
    assign rd_take = I_RD_REQ && (state_reg.mode == MODE_QUERY);
    assign rom_bus.rd_en = rd_take;
    assign rom_bus.addr = I_ADDR;

    // ============================================================
    // Next state
    // Exit wins over enter in the same cycle; the read pipeline is not
    // disturbed by a mode change, so a taken read always answers.
    always_comb
    begin
        state_next = state_reg;
        if (I_QUERY_EXIT)
        begin
            state_next.mode = MODE_ARRAY;
        end
        else if (I_QUERY_ENTER)
        begin
            state_next.mode = MODE_QUERY;
        end
        state_next.rd_pend = rd_take;
        state_next.rd_valid = state_reg.rd_pend;
        if (state_reg.rd_pend)
        begin
            state_next.dq = {`QS_UPPER_BYTE, rom_bus.data[7:0]};
        end
    end

    // State register with synchronous reset.
    always_ff @(posedge I_REF_CLK)
    begin
        if (!I_RSTN)
        begin
            state_reg <= '{mode: MODE_ARRAY, rd_pend: 1'b0, rd_valid: 1'b0, dq: `QS_DQ_RESET};
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from the state register.
    assign O_DQ = state_reg.dq;
    assign O_RD_VALID = state_reg.rd_valid;
    assign O_QUERY_MODE = (state_reg.mode == MODE_QUERY);

    // ============================================================
    // Checks
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);

    // Expected density-dependent bytes.
    localparam logic [7:0] exp_buf_typ = (DENSITY == DENS_1024) ? `QV_BUF_TYP_BIG : `QV_BUF_TYP_SMALL;
    localparam logic [7:0] exp_buf_max = (DENSITY == DENS_1024) ? `QV_BUF_MAX_BIG : `QV_BUF_MAX_SMALL;

    // A taken read of one offset answers two edges later with that byte.
    property p_word(logic [7:0] ofs, logic [7:0] val);
        (rd_take && I_ADDR == ADDR_W'(ofs)) |-> ##2 (O_RD_VALID && O_DQ == {8'h00, val});
    endproperty

    a_array_silent: assert property ((I_RD_REQ && !O_QUERY_MODE) |-> ##2 !O_RD_VALID)
        else $error("Read outside query mode was answered.");

    a_mode_enter: assert property ((I_QUERY_ENTER && !I_QUERY_EXIT) |=> O_QUERY_MODE)
        else $error("Enter did not select query mode.");

    a_mode_exit: assert property (I_QUERY_EXIT |=> !O_QUERY_MODE)
        else $error("Exit did not leave query mode.");

    a_valid_cause: assert property (O_RD_VALID |-> $past(rd_take, 2))
        else $error("Answer without a taken read.");

    a_low_byte: assert property (p_word(`QO_VCC_MAX, `QV_VCC_MAX))
        else $error("Low byte did not carry the entry.");

    a_upper_zero: assert property (O_RD_VALID |-> O_DQ[15:8] == 8'h00)
        else $error("Upper data byte not zero.");

    a_word_offset: assert property (p_word(`QO_SIG_Q, `QV_SIG_Q))
        else $error("Table does not start at word 10h.");

    a_sig_r: assert property (p_word(`QO_SIG_R, `QV_SIG_R))
        else $error("Offset 11h did not return R.");

    a_sig_y: assert property (p_word(`QO_SIG_Y, `QV_SIG_Y))
        else $error("Offset 12h did not return Y.");

    a_cmd_low: assert property (p_word(`QO_CMD_LO, CMD_SET_CODE[7:0]))
        else $error("Command-set code low byte wrong.");

    a_cmd_high: assert property (p_word(`QO_CMD_HI, CMD_SET_CODE[15:8]))
        else $error("Command-set code high byte wrong.");

    a_ext_low: assert property (p_word(`QO_EXT_LO, `QV_EXT_LO))
        else $error("Extended pointer low byte wrong.");

    a_ext_high: assert property (p_word(`QO_EXT_HI, `QV_EXT_HI))
        else $error("Extended pointer high byte wrong.");

    a_alt_code: assert property ((rd_take && (I_ADDR == ADDR_W'(`QO_ALT_LO) || I_ADDR == ADDR_W'(`QO_ALT_HI)))
        |-> ##2 O_DQ == 16'h0000)
        else $error("Alternate command-set code not zero.");

    a_sec_ptr: assert property ((rd_take && (I_ADDR == ADDR_W'(`QO_SEC_LO) || I_ADDR == ADDR_W'(`QO_SEC_HI)))
        |-> ##2 O_DQ == 16'h0000)
        else $error("Secondary table pointer not zero.");

    a_core_min: assert property (p_word(`QO_VCC_MIN, `QV_VCC_MIN))
        else $error("Core supply minimum wrong.");

    a_core_max: assert property (p_word(`QO_VCC_MAX, `QV_VCC_MAX))
        else $error("Core supply maximum wrong.");

    a_prog_min: assert property (p_word(`QO_VPP_MIN, `QV_VPP_MIN))
        else $error("Programming supply minimum wrong.");

    a_prog_max: assert property (p_word(`QO_VPP_MAX, `QV_VPP_MAX))
        else $error("Programming supply maximum wrong.");

    a_word_typ: assert property (p_word(`QO_WORD_TYP, `QV_WORD_TYP))
        else $error("Word program exponent wrong.");

    a_buf_typ: assert property (p_word(`QO_BUF_TYP, exp_buf_typ))
        else $error("Buffer write exponent wrong.");

    a_erase_typ: assert property (p_word(`QO_ERASE_TYP, `QV_ERASE_TYP))
        else $error("Block erase exponent wrong.");

    a_chip_typ: assert property (p_word(`QO_CHIP_TYP, `QV_NONE))
        else $error("Typical chip erase entry not zero.");

    a_chip_max: assert property (p_word(`QO_CHIP_MAX, `QV_NONE))
        else $error("Maximum chip erase entry not zero.");

    a_word_max: assert property (p_word(`QO_WORD_MAX, `QV_WORD_MAX))
        else $error("Word program multiplier wrong.");

    a_buf_max: assert property (p_word(`QO_BUF_MAX, exp_buf_max))
        else $error("Buffer write multiplier wrong.");

    a_erase_max: assert property (p_word(`QO_ERASE_MAX, `QV_ERASE_MAX))
        else $error("Block erase multiplier wrong.");

    a_reserved_zero: assert property ((rd_take && I_ADDR != '0 && I_ADDR <= ADDR_W'(`QO_RSV_LAST))
        |-> ##2 (O_RD_VALID && O_DQ == 16'h0000))
        else $error("Reserved offset carried data.");

    a_undef_zero: assert property ((rd_take && (I_ADDR > ADDR_W'(`QO_CHIP_MAX) || I_ADDR == '0))
        |-> ##2 (O_RD_VALID && O_DQ == 16'h0000))
        else $error("Undefined offset not zero.");

    a_dq_hold: assert property ((!state_reg.rd_pend ##1 !O_RD_VALID) |-> $stable(O_DQ))
        else $error("Data changed without an answer.");

    // ============================================================
    // Mode and pipeline checks
    // The mode register must only move on a command, so a stray
    // toggle cannot hide or expose the table between host reads.
    a_mode_hold: assert property ((!I_QUERY_ENTER && !I_QUERY_EXIT) |=> $stable(O_QUERY_MODE))
        else $error("Query mode changed without a command.");

    // Exit has priority when both commands arrive together.
    a_exit_wins: assert property ((I_QUERY_ENTER && I_QUERY_EXIT) |=> !O_QUERY_MODE)
        else $error("Enter won over exit.");

    // Every taken read must be answered exactly two edges later.
    a_taken_answers: assert property (rd_take |-> ##2 O_RD_VALID)
        else $error("Taken read was not answered.");

    // The first signature letter sits at the start of the table.
    a_sig_q: assert property (p_word(`QO_SIG_Q, `QV_SIG_Q))
        else $error("Offset 10h did not return Q.");

    // The answer of a refused read must never appear later either.
    a_refused_quiet: assert property ((!rd_take ##1 1'b1) |-> ##1 (!O_RD_VALID || $past(rd_take, 2)))
        else $error("Refused read produced an answer.");

    // Upper data byte stays zero even between answers.
    a_upper_idle: assert property (!O_RD_VALID |-> O_DQ[15:8] == 8'h00)
        else $error("Upper data byte not zero while idle.");

    // Main scenarios.
    c_signature: cover property (rd_take && I_ADDR == ADDR_W'(`QO_SIG_Q) ##2 O_RD_VALID);

    c_back_to_back: cover property (rd_take ##1 rd_take ##1 O_RD_VALID ##1 O_RD_VALID);

    c_enter_read: cover property (I_QUERY_ENTER ##1 rd_take ##2 O_RD_VALID);

    c_exit_pending: cover property (rd_take ##1 I_QUERY_EXIT ##1 O_RD_VALID);

    // Both commands at once, resolved towards array mode.
    c_exit_wins: cover property (I_QUERY_ENTER && I_QUERY_EXIT ##1 !O_QUERY_MODE);
endmodule
`default_nettype wire

// ===== bench/query_host.sv
// Purpose: Host model that enters query mode and reads table words.
// Assumes: Pins change at the falling edge; answers are taken at rising edges.
// Notes: The address shows the inverse of its last value while no read is asked.
`timescale 1ns/1ps
`default_nettype none
module query_host
#(
    parameter int ADDR_W = 26
)
(
    // Clock
    input wire logic i_clk,
    // Mode commands and read request
    output logic o_enter,
    output logic o_exit,
    output logic o_rd_req,
    output logic [ADDR_W-1:0] o_addr,
    // Answer
    input wire logic [15:0] i_dq,
    input wire logic i_rd_valid
);
    logic [15:0] got [0:15];
    int n_got;
    // ============================================================
    // Idle levels
    // All requests start idle so the device sees no command at power-up.
    initial
    begin
        o_enter = 1'b0;
        o_exit = 1'b0;
        o_rd_req = 1'b0;
        o_addr = '0;
        n_got = 0;
    end
    // Records up to 16 answered words in arrival order.
    always @(posedge i_clk)
    begin
        if (i_rd_valid === 1'b1 && n_got < 16)
        begin
            got[n_got] <= i_dq;
            n_got <= n_got + 1;
        end
    end
    // ============================================================
    // Tasks
    // Gives one cycle of mode commands.
    task automatic set_mode(input logic en, input logic ex);
        @(negedge i_clk);
        o_enter = en;
        o_exit = ex;
        @(negedge i_clk);
        o_enter = 1'b0;
        o_exit = 1'b0;
    endtask
    // Issues n back-to-back reads and counts cycles until all answers are in.
    task automatic read_words(input logic [ADDR_W-1:0] base, input int n, output int wait_cyc);
        int i;
        n_got = 0;
        for (i = 0; i < n; i++)
        begin
            @(negedge i_clk);
            o_rd_req = 1'b1;
            o_addr = base + ADDR_W'(i);
        end
        @(negedge i_clk);
        o_rd_req = 1'b0;
        o_addr = ~o_addr;
        wait_cyc = 0;
        while (n_got < n && wait_cyc < 6)
        begin
            @(negedge i_clk);
            wait_cyc++;
        end
    endtask
endmodule
`default_nettype wire

// ===== bench/test_flash_query_info_table.sv
// Purpose: Self-checking bench for the query table.
// Assumes: The host model drives mode and read pins at the falling edge.
// Notes: A second instance of the smaller density checks the density-dependent bytes.
`timescale 1ns/1ps
`default_nettype none
module test_flash_query_info_table;
    import query_pkg::*;
    // Command-set code value is arbitrary.
    localparam logic [15:0] CMD_CODE = 16'h3C5A;
    logic ref_clk;
    logic rstn;
    logic q_enter;
    logic q_exit;
    logic rd_req;
    logic [25:0] addr;
    logic [15:0] dq;
    logic [15:0] dq_small;
    logic rd_valid;
    logic rd_valid_small;
    logic query_mode;
    logic query_mode_small;
    logic [15:0] last_small;
    int n_mismatch;
    int cmp_count;
    int lat;
    logic [7:0] tab [0:22] = '{8'h51, 8'h52, 8'h59, 8'h00, 8'h00, 8'h0A, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h17, 8'h20, 8'h85, 8'h95, 8'h06, 8'h0B, 8'h0A, 8'h00, 8'h02, 8'h01, 8'h02, 8'h00};
    // ============================================================
    // Instances
    flash_query_info_table #(.ADDR_W(26), .DENSITY(DENS_1024), .CMD_SET_CODE(CMD_CODE)) dut
    (.I_REF_CLK(ref_clk), .I_RSTN(rstn), .I_QUERY_ENTER(q_enter), .I_QUERY_EXIT(q_exit), .I_RD_REQ(rd_req),
     .I_ADDR(addr), .O_DQ(dq), .O_RD_VALID(rd_valid), .O_QUERY_MODE(query_mode));
    flash_query_info_table #(.ADDR_W(26), .DENSITY(DENS_256), .CMD_SET_CODE(CMD_CODE)) dut_small
    (.I_REF_CLK(ref_clk), .I_RSTN(rstn), .I_QUERY_ENTER(q_enter), .I_QUERY_EXIT(q_exit), .I_RD_REQ(rd_req),
     .I_ADDR(addr), .O_DQ(dq_small), .O_RD_VALID(rd_valid_small), .O_QUERY_MODE(query_mode_small));
    query_host #(.ADDR_W(26)) host
    (.i_clk(ref_clk), .o_enter(q_enter), .o_exit(q_exit), .o_rd_req(rd_req), .o_addr(addr),
     .i_dq(dq), .i_rd_valid(rd_valid));
    // Clock of 20 ns period.
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Keeps the last answer of the smaller density.
    always @(posedge ref_clk)
    begin
        if (rd_valid_small === 1'b1)
            last_small <= dq_small;
    end
    // ============================================================
    // Helpers
    // Works out the expected word of an address.
    function automatic logic [15:0] exp_word(input logic [25:0] a, input logic big);
        logic [7:0] b;
        b = 8'h00;
        if (a >= 26'h10 && a <= 26'h26)
            b = tab[a - 26'h10];
        if (a == 26'h13)
            b = CMD_CODE[7:0];
        if (a == 26'h14)
            b = CMD_CODE[15:8];
        if (!big && a == 26'h20)
            b = 8'h0A;
        if (!big && a == 26'h24)
            b = 8'h02;
        return {8'h00, b};
    endfunction
    task automatic check16(input string what, input logic [15:0] exp, input logic [15:0] seen);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reads words that must be answered; a used-up wait ends the run.
    task automatic rd(input logic [25:0] a, input int n);
        host.read_words(a, n, lat);
        check16("answer latency", 16'h0002, 16'(lat));
        if (lat >= 6)
        begin
            n_mismatch++;
            give_verdict();
        end
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        check16("reset word", 16'h0000, dq);
        check16("reset mode", 16'h0000, {14'h0000, rd_valid, query_mode});
    endtask
    task automatic t_refused();
        host.read_words(26'h10, 1, lat);
        check16("array mode answers", 16'h0000, 16'(host.n_got));
    endtask
    task automatic scan(input logic [25:0] lo, input logic [25:0] hi);
        logic [25:0] a;
        for (a = lo; a <= hi; a++)
        begin
            rd(a, 1);
            check16("table word", exp_word(a, 1'b1), host.got[0]);
        end
    endtask
    task automatic t_table();
        host.set_mode(1'b1, 1'b0);
        check16("mode after enter", 16'h0001, {15'h0000, query_mode});
        check16("small mode after enter", 16'h0001, {15'h0000, query_mode_small});
        scan(26'h00, 26'h1A);
        scan(26'h1B, 26'h2F);
        rd(26'h200_0010, 1);
        check16("high address word", 16'h0000, host.got[0]);
    endtask
    task automatic t_burst();
        rd(26'h10, 3);
        check16("burst Q", 16'h0051, host.got[0]);
        check16("burst R", 16'h0052, host.got[1]);
        check16("burst Y", 16'h0059, host.got[2]);
    endtask
    task automatic t_small();
        rd(26'h20, 1);
        check16("small buffer exponent", exp_word(26'h20, 1'b0), last_small);
        rd(26'h24, 1);
        check16("small buffer multiplier", exp_word(26'h24, 1'b0), last_small);
    endtask
    task automatic t_exit();
        host.set_mode(1'b1, 1'b1);
        check16("exit over enter", 16'h0000, {15'h0000, query_mode});
        host.set_mode(1'b1, 1'b1);
        check16("mode stays array", 16'h0000, {15'h0000, query_mode});
        host.read_words(26'h11, 1, lat);
        check16("answers after exit", 16'h0000, 16'(host.n_got));
    endtask
    // ============================================================
    // Main sequence
    initial
    begin
        n_mismatch = 0;
        cmp_count = 0;
        rstn = 1'b0;
        repeat (2) @(negedge ref_clk);
        t_reset();
        rstn = 1'b1;
        t_refused();
        t_table();
        t_burst();
        t_small();
        t_exit();
        give_verdict();
    end
endmodule
`default_nettype wire
